// >>> core/cs_mux_pkg.sv
// shared constants and types for the chip-select pin multiplexer
package cs_mux_pkg;

    // register bus geometry and map
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 8;
    localparam logic [3:0]  OFS_CS_ENABLE   = 4'h0;
    localparam logic [3:0]  OFS_PIN_CHOICE  = 4'h1;
    localparam logic [7:0]  RST_CS_ENABLE   = 8'h01;
    localparam logic [7:0]  RST_PIN_CHOICE  = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ   = 8'h00;

    // strobes and pins
    localparam int          NUM_STROBES     = 8;
    localparam int          NUM_PINS        = 7;
    localparam int          FIRST_ROUTED    = 4;
    localparam int          ROUTE_W         = 2;

    // pin indices of the pin vectors
    localparam int          PIN_PORTB_BIT0  = 0;
    localparam int          PIN_PORTB_BIT1  = 1;
    localparam int          PIN_PORTB_BIT2  = 2;
    localparam int          PIN_PORTB_BIT3  = 3;
    localparam int          PIN_PORTF_BIT5  = 4;
    localparam int          PIN_PORTF_BIT6  = 5;
    localparam int          PIN_PORTF_BIT7  = 6;

    // route codes
    localparam logic [1:0]  CODE_A          = 2'h0;
    localparam logic [1:0]  CODE_B          = 2'h1;
    localparam logic [1:0]  CODE_C          = 2'h2;
    localparam logic [1:0]  CODE_D          = 2'h3;

    // one-hot pin vector per strobe and code; all zero means prohibited
    localparam logic [6:0]  ROUTE_TBL [NUM_STROBES][4] = '{
        '{7'h01, 7'h01, 7'h01, 7'h01},
        '{7'h02, 7'h02, 7'h02, 7'h02},
        '{7'h04, 7'h04, 7'h04, 7'h04},
        '{7'h08, 7'h08, 7'h08, 7'h08},
        '{7'h01, 7'h00, 7'h40, 7'h00},
        '{7'h02, 7'h01, 7'h40, 7'h10},
        '{7'h04, 7'h02, 7'h40, 7'h20},
        '{7'h08, 7'h02, 7'h40, 7'h00}
    };

    // drive of one pin
    typedef struct packed {
        logic level;
        logic oe;
        logic strobe_fn;
    } pin_drive_t;

endpackage : cs_mux_pkg

// >>> core/chip_select_pin_mux.sv
// chip-select pin multiplexer: enable and pin-choice registers plus pin steering
module chip_select_pin_mux (
    input  wire logic                CLK,
    input  wire logic                RSTN,
    input  wire logic [3:0]          ADDR,
    input  wire logic [7:0]          WDATA,
    input  wire logic                WE,
    input  wire logic                RE,
    output      logic [7:0]          RDATA,
    input  wire logic [7:0]          CS_N,
    input  wire logic [6:0]          GPIO_OUT,
    input  wire logic [6:0]          GPIO_OE,
    output      logic [6:0]          PIN_OUT,
    output      logic [6:0]          PIN_OE,
    output      logic [6:0]          PIN_STROBE_FN
);

    logic [7:0]                      enable_q;
    logic [7:0]                      choice_q;
    logic [7:0]                      rdata_q;
    cs_mux_pkg::pin_drive_t [6:0]    drive_q;
    cs_mux_pkg::pin_drive_t [6:0]    drive_d;
    logic [6:0]                      hot [cs_mux_pkg::NUM_STROBES];

    // address decode
    wire sel_enable = (ADDR == cs_mux_pkg::OFS_CS_ENABLE);
    wire sel_choice = (ADDR == cs_mux_pkg::OFS_PIN_CHOICE);
    wire wr_enable  = WE && sel_enable;
    wire wr_choice  = WE && sel_choice;
    wire [7:0] rd_mux = sel_enable ? enable_q :
                        sel_choice ? choice_q : cs_mux_pkg::UNMAPPED_READ;

    // control registers; the bus never waits so writes land at once
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            enable_q <= cs_mux_pkg::RST_CS_ENABLE;
            choice_q <= cs_mux_pkg::RST_PIN_CHOICE;
        end else begin
            if (wr_enable) begin
                enable_q <= WDATA;
            end
            if (wr_choice) begin
                choice_q <= WDATA;
            end
        end
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            rdata_q <= cs_mux_pkg::UNMAPPED_READ;
        end else begin
            rdata_q <= RE ? rd_mux : cs_mux_pkg::UNMAPPED_READ;
        end
    end

    assign RDATA = rdata_q;

    // per strobe: one-hot pin vector, gated by its enable
    for (genvar s = 0; s < cs_mux_pkg::NUM_STROBES; s++) begin : g_strobe
        logic [1:0] code;
        if (s >= cs_mux_pkg::FIRST_ROUTED) begin : g_routed
            assign code = choice_q[cs_mux_pkg::ROUTE_W*(s-cs_mux_pkg::FIRST_ROUTED)
                                   +: cs_mux_pkg::ROUTE_W];
        end else begin : g_fixed
            assign code = cs_mux_pkg::CODE_A;
        end
        // a prohibited code yields an empty vector, leaving the pin a port bit
        assign hot[s] = enable_q[s] ? cs_mux_pkg::ROUTE_TBL[s][code] : 7'h00;
    end

    // per pin: gather strobes, wired-and of active-low strobes
    for (genvar p = 0; p < cs_mux_pkg::NUM_PINS; p++) begin : g_pin
        logic [7:0] on_pin;
        for (genvar s = 0; s < cs_mux_pkg::NUM_STROBES; s++) begin : g_gather
            assign on_pin[s] = hot[s][p];
        end
        wire fn    = |on_pin;
        wire level = &(CS_N | ~on_pin);
        assign drive_d[p].strobe_fn = fn;
        assign drive_d[p].level     = fn ? level : GPIO_OUT[p];
        assign drive_d[p].oe        = fn ? 1'b1 : GPIO_OE[p];
    end

    // pin drive register; one cycle of latency, glitch-free pins
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            drive_q <= '0;
        end else begin
            drive_q <= drive_d;
        end
    end

    for (genvar p = 0; p < cs_mux_pkg::NUM_PINS; p++) begin : g_out
        assign PIN_OUT[p]       = drive_q[p].level;
        assign PIN_OE[p]        = drive_q[p].oe;
        assign PIN_STROBE_FN[p] = drive_q[p].strobe_fn;
    end

    // checks: sampled on the bus clock and quiet while reset is held
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // pin-choice fields as software sees them
    wire [1:0] code4 = choice_q[1:0];
    wire [1:0] code5 = choice_q[3:2];
    wire [1:0] code6 = choice_q[5:4];
    wire [1:0] code7 = choice_q[7:6];

    // register accesses; a read may follow a write with no idle cycle
    sequence s_write_enable;
        WE && sel_enable;
    endsequence

    sequence s_read_enable;
        RE && sel_enable && !WE;
    endsequence

    sequence s_write_choice;
        WE && sel_choice;
    endsequence

    sequence s_read_choice;
        RE && sel_choice && !WE;
    endsequence

    sequence s_read_unmapped;
        RE && !sel_enable && !sel_choice;
    endsequence

    // a write is visible to a read in the very next cycle
    a_enable_readback: assert property (
        s_write_enable ##1 s_read_enable |=> RDATA == $past(WDATA, 2))
        else $error("enable register readback mismatch");

    a_choice_readback: assert property (
        s_write_choice ##1 s_read_choice |=> RDATA == $past(WDATA, 2))
        else $error("pin-choice register readback mismatch");

    // holes in the map read as zero, and so does the bus between reads
    a_unmapped_read: assert property (
        s_read_unmapped |=> RDATA == cs_mux_pkg::UNMAPPED_READ)
        else $error("unmapped address returned data");

    a_idle_rdata: assert property (
        !RE |=> RDATA == cs_mux_pkg::UNMAPPED_READ)
        else $error("read data left standing without a read");

    // fixed strobes: one pin each, a low strobe pulls its pin low
    // port B bits 0 to 3 sit at pin indices 0 to 3, so the strobe number is the pin
    a_strobe0_drives: assert property (
        enable_q[0] && !CS_N[0] |=> PIN_STROBE_FN[cs_mux_pkg::PIN_PORTB_BIT0]
            && PIN_OE[cs_mux_pkg::PIN_PORTB_BIT0] && !PIN_OUT[cs_mux_pkg::PIN_PORTB_BIT0])
        else $error("strobe 0 not driven on port B bit 0");

    for (genvar s = 1; s < cs_mux_pkg::FIRST_ROUTED; s++) begin : g_fixed_chk
        a_fixed_strobe: assert property (
            enable_q[s] && !CS_N[s] |=> PIN_STROBE_FN[s] && PIN_OE[s] && !PIN_OUT[s])
            else $error("fixed strobe not driven on its port B pin");
    end

    // every pin stays a port bit while all strobes are disabled
    a_all_disabled: assert property (
        enable_q == '0 |=> PIN_STROBE_FN == '0 && PIN_OUT == $past(GPIO_OUT)
            && PIN_OE == $past(GPIO_OE))
        else $error("pin left port function with every strobe disabled");

    for (genvar p = 0; p < cs_mux_pkg::NUM_PINS; p++) begin : g_pin_chk
        // a strobe pin is always driven
        a_strobe_oe: assert property (
            PIN_STROBE_FN[p] |-> PIN_OE[p])
            else $error("strobe pin not driven");
        // the first cycle out of reset shows the cleared register, not port data
        a_port_level: assert property (
            $past(RSTN) && !PIN_STROBE_FN[p]
                |-> PIN_OUT[p] == $past(GPIO_OUT[p]) && PIN_OE[p] == $past(GPIO_OE[p]))
            else $error("port pin lost its port data");
    end

    // a cleared enable keeps the code D route of strobes 6 and 5 off their port F pins
    a_disabled_port: assert property (
        !enable_q[6] && code6 == cs_mux_pkg::CODE_D
            |=> !PIN_STROBE_FN[cs_mux_pkg::PIN_PORTF_BIT6]
            && PIN_OUT[cs_mux_pkg::PIN_PORTF_BIT6]
                == $past(GPIO_OUT[cs_mux_pkg::PIN_PORTF_BIT6]))
        else $error("disabled strobe 6 still routed");

    a_disabled_port_f5: assert property (
        !enable_q[5] && code5 == cs_mux_pkg::CODE_D
            |=> !PIN_STROBE_FN[cs_mux_pkg::PIN_PORTF_BIT5]
            && PIN_OE[cs_mux_pkg::PIN_PORTF_BIT5]
                == $past(GPIO_OE[cs_mux_pkg::PIN_PORTF_BIT5]))
        else $error("disabled strobe 5 still routed");

    // strobe 7: three legal pins, and no pin for the prohibited code
    a_strobe7_port_b3: assert property (
        enable_q[7] && code7 == cs_mux_pkg::CODE_A && !CS_N[7]
            |=> PIN_STROBE_FN[cs_mux_pkg::PIN_PORTB_BIT3]
            && !PIN_OUT[cs_mux_pkg::PIN_PORTB_BIT3])
        else $error("strobe 7 not on port B bit 3");

    a_strobe7_port_b1: assert property (
        enable_q[7] && code7 == cs_mux_pkg::CODE_B && !CS_N[7]
            |=> PIN_STROBE_FN[cs_mux_pkg::PIN_PORTB_BIT1]
            && !PIN_OUT[cs_mux_pkg::PIN_PORTB_BIT1])
        else $error("strobe 7 not on port B bit 1");

    a_strobe7_route: assert property (
        enable_q[7] && code7 == cs_mux_pkg::CODE_C && !CS_N[7]
            |=> !PIN_OUT[cs_mux_pkg::PIN_PORTF_BIT7]
            && PIN_STROBE_FN[cs_mux_pkg::PIN_PORTF_BIT7])
        else $error("strobe 7 not on port F bit 7");

    // only strobe 3 may claim port B bit 3 besides strobe 7
    a_strobe7_banned: assert property (
        enable_q[7] && code7 == cs_mux_pkg::CODE_D && !enable_q[3]
            |=> !PIN_STROBE_FN[cs_mux_pkg::PIN_PORTB_BIT3])
        else $error("prohibited strobe 7 code routed a pin");

    // strobe 6: four pins, port F bit 6 is its alone
    a_strobe6_port_b2: assert property (
        enable_q[6] && code6 == cs_mux_pkg::CODE_A && !CS_N[6]
            |=> PIN_STROBE_FN[cs_mux_pkg::PIN_PORTB_BIT2]
            && !PIN_OUT[cs_mux_pkg::PIN_PORTB_BIT2])
        else $error("strobe 6 not on port B bit 2");

    a_strobe6_port_b1: assert property (
        enable_q[6] && code6 == cs_mux_pkg::CODE_B && !CS_N[6]
            |=> PIN_STROBE_FN[cs_mux_pkg::PIN_PORTB_BIT1]
            && !PIN_OUT[cs_mux_pkg::PIN_PORTB_BIT1])
        else $error("strobe 6 not on port B bit 1");

    a_strobe6_port_f7: assert property (
        enable_q[6] && code6 == cs_mux_pkg::CODE_C && !CS_N[6]
            |=> PIN_STROBE_FN[cs_mux_pkg::PIN_PORTF_BIT7]
            && !PIN_OUT[cs_mux_pkg::PIN_PORTF_BIT7])
        else $error("strobe 6 not on port F bit 7");

    a_strobe6_route: assert property (
        enable_q[6] && code6 == cs_mux_pkg::CODE_D
            |=> PIN_STROBE_FN[cs_mux_pkg::PIN_PORTF_BIT6]
            && PIN_OUT[cs_mux_pkg::PIN_PORTF_BIT6] == $past(CS_N[6]))
        else $error("strobe 6 not on port F bit 6");

    // strobe 5: four pins, port F bit 5 is its alone
    a_strobe5_port_b1: assert property (
        enable_q[5] && code5 == cs_mux_pkg::CODE_A && !CS_N[5]
            |=> PIN_STROBE_FN[cs_mux_pkg::PIN_PORTB_BIT1]
            && !PIN_OUT[cs_mux_pkg::PIN_PORTB_BIT1])
        else $error("strobe 5 not on port B bit 1");

    a_strobe5_port_b0: assert property (
        enable_q[5] && code5 == cs_mux_pkg::CODE_B && !CS_N[5]
            |=> PIN_STROBE_FN[cs_mux_pkg::PIN_PORTB_BIT0]
            && !PIN_OUT[cs_mux_pkg::PIN_PORTB_BIT0])
        else $error("strobe 5 not on port B bit 0");

    a_strobe5_port_f7: assert property (
        enable_q[5] && code5 == cs_mux_pkg::CODE_C && !CS_N[5]
            |=> PIN_STROBE_FN[cs_mux_pkg::PIN_PORTF_BIT7]
            && !PIN_OUT[cs_mux_pkg::PIN_PORTF_BIT7])
        else $error("strobe 5 not on port F bit 7");

    a_strobe5_route: assert property (
        enable_q[5] && code5 == cs_mux_pkg::CODE_D
            |=> PIN_STROBE_FN[cs_mux_pkg::PIN_PORTF_BIT5]
            && PIN_OUT[cs_mux_pkg::PIN_PORTF_BIT5] == $past(CS_N[5]))
        else $error("strobe 5 not on port F bit 5");

    // strobe 4: two legal pins; prohibited code B must leave port B bit 0 alone
    a_strobe4_port_b0: assert property (
        enable_q[4] && code4 == cs_mux_pkg::CODE_A && !CS_N[4]
            |=> PIN_STROBE_FN[cs_mux_pkg::PIN_PORTB_BIT0]
            && !PIN_OUT[cs_mux_pkg::PIN_PORTB_BIT0])
        else $error("strobe 4 not on port B bit 0");

    a_strobe4_port_f7: assert property (
        enable_q[4] && code4 == cs_mux_pkg::CODE_C && !CS_N[4]
            |=> PIN_STROBE_FN[cs_mux_pkg::PIN_PORTF_BIT7]
            && !PIN_OUT[cs_mux_pkg::PIN_PORTF_BIT7])
        else $error("strobe 4 not on port F bit 7");

    a_strobe4_banned: assert property (
        enable_q[4] && code4 == cs_mux_pkg::CODE_B && !enable_q[0] && !enable_q[5]
            |=> !PIN_STROBE_FN[cs_mux_pkg::PIN_PORTB_BIT0])
        else $error("prohibited strobe 4 code routed a pin");

    // shared pins: any low strobe pulls the pin low, all high leave it high
    a_shared_pin: assert property (
        enable_q[6] && enable_q[7] && code6 == cs_mux_pkg::CODE_C
            && code7 == cs_mux_pkg::CODE_C && (CS_N[6] ^ CS_N[7])
            |=> !PIN_OUT[cs_mux_pkg::PIN_PORTF_BIT7])
        else $error("shared pin lost one strobe");

    a_shared_pin_b1: assert property (
        enable_q[5] && enable_q[7] && code5 == cs_mux_pkg::CODE_A
            && code7 == cs_mux_pkg::CODE_B && (CS_N[5] ^ CS_N[7])
            |=> PIN_STROBE_FN[cs_mux_pkg::PIN_PORTB_BIT1]
            && !PIN_OUT[cs_mux_pkg::PIN_PORTB_BIT1])
        else $error("shared port B bit 1 lost one strobe");

    a_shared_pin_high: assert property (
        (&enable_q[7:4]) && {code7, code6, code5, code4} == {4{cs_mux_pkg::CODE_C}}
            && (&CS_N[7:4]) |=> PIN_OUT[cs_mux_pkg::PIN_PORTF_BIT7])
        else $error("shared pin low with every strobe on it high");

endmodule : chip_select_pin_mux

// >>> tb/cs_mem_model.sv
// external memory devices hanging off the chip-select pins
module cs_mem_model (
    input  wire logic [6:0] pin_out,
    input  wire logic [6:0] pin_oe,
    input  wire logic [6:0] pin_strobe_fn,
    output      logic [6:0] selected
);
    timeunit 1ns;
    timeprecision 1ps;
    // a device wakes only on a driven strobe; port traffic must never select it
    assign selected = pin_oe & pin_strobe_fn & ~pin_out;
endmodule : cs_mem_model

// >>> tb/tb.sv
// self-checking bench for the chip-select pin multiplexer
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       CLK, RSTN, WE, RE;
    logic [3:0] ADDR;
    logic [7:0] WDATA, RDATA, CS_N, en, ch, d;
    logic [6:0] GPIO_OUT, GPIO_OE, PIN_OUT, PIN_OE, PIN_STROBE_FN, sel;
    int         n_errors, n_checks;
    // pin vector per strobe and route code; zero where a code is prohibited
    localparam logic [6:0] MAP [8][4] = '{
        '{7'h01, 7'h01, 7'h01, 7'h01}, '{7'h02, 7'h02, 7'h02, 7'h02},
        '{7'h04, 7'h04, 7'h04, 7'h04}, '{7'h08, 7'h08, 7'h08, 7'h08},
        '{7'h01, 7'h00, 7'h40, 7'h00}, '{7'h02, 7'h01, 7'h40, 7'h10},
        '{7'h04, 7'h02, 7'h40, 7'h20}, '{7'h08, 7'h02, 7'h40, 7'h00}};

    chip_select_pin_mux i_dut (.CLK, .RSTN, .ADDR, .WDATA, .WE, .RE, .RDATA, .CS_N,
        .GPIO_OUT, .GPIO_OE, .PIN_OUT, .PIN_OE, .PIN_STROBE_FN);
    cs_mem_model i_mem (.pin_out(PIN_OUT), .pin_oe(PIN_OE), .pin_strobe_fn(PIN_STROBE_FN),
        .selected(sel));

    // expected {out, oe, fn}; strobes sharing a pin combine, any low pulls it low
    function automatic logic [20:0] pins_exp(logic [7:0] e, c, cs, logic [6:0] go, goe);
        logic [6:0] o, oe, fn;
        logic [1:0] code;
        o = go;
        oe = goe;
        fn = '0;
        for (int p = 0; p < 7; p++) begin
            for (int s = 0; s < 8; s++) begin
                code = (s < 4) ? 2'h0 : c[2*(s-4) +: 2];
                if (e[s] && MAP[s][code][p]) begin
                    o[p] = fn[p] ? (o[p] & cs[s]) : cs[s];
                    oe[p] = 1'b1;
                    fn[p] = 1'b1;
                end
            end
        end
        return {o, oe, fn};
    endfunction : pins_exp

    task chk(input string nm, input logic [20:0] e, input logic [20:0] s);
        n_checks++;
        if (s !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
            n_errors++;
        end
    endtask : chk

    task end_sim;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim

    // register write, shadowed so expectations follow software's view
    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= v;
        WE <= 1'b1;
        @(posedge CLK);
        WE <= 1'b0;
        if (a == cs_mux_pkg::OFS_CS_ENABLE) en = v;
        if (a == cs_mux_pkg::OFS_PIN_CHOICE) ch = v;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge CLK);
        ADDR <= a;
        RE <= 1'b1;
        @(posedge CLK);
        RE <= 1'b0;
        #1 chk("rdata", 21'(e), 21'(RDATA));
    endtask : rd

    // write then read back with no idle cycle between the strobes
    task wr_rd(input logic [3:0] a, input logic [7:0] v);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= v;
        WE <= 1'b1;
        @(posedge CLK);
        WE <= 1'b0;
        RE <= 1'b1;
        @(posedge CLK);
        RE <= 1'b0;
        if (a == cs_mux_pkg::OFS_CS_ENABLE) en = v;
        if (a == cs_mux_pkg::OFS_PIN_CHOICE) ch = v;
        #1 chk("rdata back to back", 21'(v), 21'(RDATA));
    endtask : wr_rd

    // one pin sample with random port traffic, seen one cycle later
    task step(input logic [7:0] cs);
        logic [20:0] x;
        @(posedge CLK);
        CS_N <= cs;
        GPIO_OUT <= 7'($urandom);
        GPIO_OE <= 7'($urandom);
        @(posedge CLK);
        #1 x = pins_exp(en, ch, CS_N, GPIO_OUT, GPIO_OE);
        chk("pins", x, {PIN_OUT, PIN_OE, PIN_STROBE_FN});
        // a device wakes only on a driven low strobe pin, never on port traffic
        chk("selected", 21'(x[13:7] & x[6:0] & ~x[20:14]), 21'(sel));
    endtask : step

    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end

    // watchdog so a stuck run still reaches the verdict
    initial begin
        repeat (100000) @(posedge CLK);
        n_errors++;
        end_sim();
    end

    initial begin
        {RSTN, WE, RE, ADDR, WDATA, CS_N, GPIO_OUT, GPIO_OE} = '0;
        en = cs_mux_pkg::RST_CS_ENABLE;
        ch = cs_mux_pkg::RST_PIN_CHOICE;
        void'($urandom(87715));
        repeat (20) @(posedge CLK);
        RSTN <= 1'b1;
        rd(cs_mux_pkg::OFS_CS_ENABLE, cs_mux_pkg::RST_CS_ENABLE);
        rd(cs_mux_pkg::OFS_PIN_CHOICE, cs_mux_pkg::RST_PIN_CHOICE);
        step(8'hFE);
        wr(4'hF, 8'h5A);
        rd(4'hF, cs_mux_pkg::UNMAPPED_READ);
        rd(cs_mux_pkg::OFS_CS_ENABLE, 8'h01);
        wr(cs_mux_pkg::OFS_CS_ENABLE, 8'h10);
        wr(cs_mux_pkg::OFS_PIN_CHOICE, 8'h01);
        step(8'h00);
        wr(cs_mux_pkg::OFS_PIN_CHOICE, 8'hFF);
        wr(cs_mux_pkg::OFS_CS_ENABLE, 8'h00);
        step(8'h00);
        wr(cs_mux_pkg::OFS_CS_ENABLE, 8'hF0);
        step(8'h00);
        wr(cs_mux_pkg::OFS_PIN_CHOICE, 8'hAA);
        for (int i = 0; i < 16; i++) step({4'(i), 4'hF});
        for (int i = 0; i < 200; i++) begin
            d = 8'($urandom);
            if (d[7:6] == 2'h3) d[7:6] = 2'h2;
            d[0] = 1'b0;
            wr_rd(cs_mux_pkg::OFS_PIN_CHOICE, d);
            wr_rd(cs_mux_pkg::OFS_CS_ENABLE, 8'($urandom));
            rd(cs_mux_pkg::OFS_PIN_CHOICE, d);
            repeat (3) step(8'($urandom));
        end
        end_sim();
    end
endmodule : tb
